// >>> inc/fbm_regs.svh
// Purpose: Timing constants for the flash bus-mode host controller
// Assumes: Core clock of 250 MHz; times given in ns
// Notes: Least times round up to whole cycles, the busy wait rounds down
`ifndef FBM_REGS_SVH
`define FBM_REGS_SVH

`define FBM_CLK_MHZ 250
`define FBM_CYC_UP(ns) ((((ns) * `FBM_CLK_MHZ) + 999) / 1000)
`define FBM_CYC_DN(ns) (((ns) * `FBM_CLK_MHZ) / 1000)

// Address access time, read data valid after this
`define FBM_ADDRESS_ACCESS_TIME_NS 70
// Write strobe low and high widths
`define FBM_T_WP_NS 35
`define FBM_T_WPH_NS 20
// Minimum clear pulse, clear-to-read recovery, busy reset bound
`define FBM_T_RP_NS 500
`define FBM_T_RH_NS 50
`define FBM_T_READY_NS 20000

`define FBM_ACC_CYC `FBM_CYC_UP(`FBM_ADDRESS_ACCESS_TIME_NS)
`define FBM_WP_CYC `FBM_CYC_UP(`FBM_T_WP_NS)
`define FBM_WPH_CYC `FBM_CYC_UP(`FBM_T_WPH_NS)
`define FBM_RP_CYC `FBM_CYC_UP(`FBM_T_RP_NS)
`define FBM_RH_CYC `FBM_CYC_UP(`FBM_T_RH_NS)
`define FBM_READY_CYC `FBM_CYC_DN(`FBM_T_READY_NS)

`endif

// >>> inc/fbm_pkg.sv
// Purpose: Types of the flash bus-mode host controller
// Assumes: Timing lives in fbm_regs.svh
// Notes: States take successive Gray codes in declaration order
package fbm_pkg;

    typedef enum logic [1:0] {
        FBM_OP_READ = 2'h0,
        FBM_OP_WRITE = 2'h1,
        FBM_OP_CLEAR = 2'h2
    } fbm_op_t;

    typedef enum logic [2:0] {
        FBM_ST_IDLE = 3'h0,
        FBM_ST_READ = 3'h1,
        FBM_ST_WR_LO = 3'h3,
        FBM_ST_WR_HI = 3'h2,
        FBM_ST_CLR_LO = 3'h6,
        FBM_ST_CLR_WAIT = 3'h7,
        FBM_ST_CLR_RECOV = 3'h5
    } fbm_state_t;

endpackage : fbm_pkg

// >>> core/fbm_host.sv
// Purpose: Host-side bus controller driving a parallel multi-bank flash
// Assumes: Flash pins sampled synchronously to core_clk_i
// Notes: Command sequences are built by the user from single write cycles
//
// Function
// - Host presents command cycles with write strobe and select low, gate high.
// - Host applies accelerate level whenever it is requested outside clear; never floats that pin.
// - Host flags an operation that a hardware clear interrupted; the user reissues it.
// - Busy flag stays low until internal clear ends; host may poll it.
// - Host waits clear-to-read time after clear release before reading.
`timescale 1ns/1ps
`include "fbm_regs.svh"

module fbm_host #(
    parameter int READY_CYC = `FBM_READY_CYC
) (
    input wire logic core_clk_i,            // 250 MHz core clock
    input wire logic nrst_i,                // Async reset, active low
    input wire logic ce_i,                  // Clock enable, freezes all state but the reset synchroniser
    input wire logic req_valid_i,           // Request offered
    input wire logic [1:0] req_op_i,        // fbm_pkg::fbm_op_t
    input wire logic [21:0] req_addr_i,     // Byte address, bit 0 used in byte mode
    input wire logic [15:0] req_wdata_i,    // Write data
    input wire logic byte_mode_i,           // 1 selects byte width
    input wire logic accel_req_i,           // Request accelerate level
    input wire logic protect_i,             // Protect level when not accelerated
    output logic req_ready_o,               // Request taken while high
    output logic rsp_valid_o,               // Completion pulse
    output logic [15:0] rsp_rdata_o,        // Read data
    output logic retry_o,                   // Interrupted operation must be reissued
    output logic flash_ce_n_o,              // Chip select, active low
    output logic flash_oe_n_o,              // Output gate, active low
    output logic flash_we_n_o,              // Write strobe, active low
    output logic flash_clear_n_o,           // Hardware clear, active low
    output logic flash_byte_n_o,            // Width select, low for bytes
    output logic flash_accel_hv_o,          // Switches accelerate level on pin
    output logic protect_accel_pin_o,       // Logic level on protect pin
    output logic [20:0] flash_addr_o,       // Word address
    output logic [15:0] data_lines_o,       // Data towards flash
    output logic [15:0] data_lines_oe_o,    // Per-line drive enable
    input wire logic [15:0] data_lines_i,   // Data from flash
    input wire logic op_done_flag_n_i       // Ready high, busy low
);

    logic [1:0] rst_sync_ff;
    logic rst_n;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    function automatic logic [15:0] cyc_m1(input int n);
        cyc_m1 = 16'(n - 1);
    endfunction : cyc_m1

    fbm_pkg::fbm_state_t st_ff, nxt_st;
    logic [15:0] cnt_ff, nxt_cnt;
    logic ready_ff, nxt_ready, rsp_ff, nxt_rsp, retry_ff, nxt_retry;
    logic [15:0] rdata_ff, nxt_rdata, dq_ff, nxt_dq, dq_oe_ff, nxt_dq_oe;
    logic ce_n_ff, nxt_ce_n, oe_n_ff, nxt_oe_n, we_n_ff, nxt_we_n, clr_n_ff, nxt_clr_n;
    logic byte_n_ff, nxt_byte_n, hv_ff, nxt_hv, prot_ff, nxt_prot;
    logic [20:0] addr_ff, nxt_addr;
    logic take;

    assign take = req_valid_i && ready_ff;

    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_rsp = 1'b0;
        nxt_retry = retry_ff;
        nxt_rdata = rdata_ff;
        nxt_dq = dq_ff;
        nxt_dq_oe = dq_oe_ff;
        nxt_ce_n = ce_n_ff;
        nxt_oe_n = oe_n_ff;
        nxt_we_n = we_n_ff;
        nxt_clr_n = clr_n_ff;
        nxt_byte_n = byte_n_ff;
        nxt_addr = addr_ff;
        unique case (st_ff)
            fbm_pkg::FBM_ST_IDLE: begin
                if (take) begin
                    nxt_byte_n = !byte_mode_i;
                    nxt_addr = req_addr_i[21:1];
                    // Top line carries the low address bit in byte width
                    nxt_dq = byte_mode_i ? {req_addr_i[0], 7'h00, req_wdata_i[7:0]}
                                         : req_wdata_i;
                    unique case (fbm_pkg::fbm_op_t'(req_op_i))
                        fbm_pkg::FBM_OP_WRITE: begin
                            nxt_ce_n = 1'b0;
                            nxt_we_n = 1'b0;
                            nxt_oe_n = 1'b1;
                            nxt_dq_oe = byte_mode_i ? 16'h80ff : 16'hffff;
                            nxt_retry = 1'b0;
                            nxt_cnt = cyc_m1(`FBM_WP_CYC);
                            nxt_st = fbm_pkg::FBM_ST_WR_LO;
                        end
                        fbm_pkg::FBM_OP_CLEAR: begin
                            nxt_clr_n = 1'b0;
                            nxt_ce_n = 1'b1;
                            nxt_oe_n = 1'b1;
                            nxt_we_n = 1'b1;
                            nxt_dq_oe = 16'h0000;
                            // Busy at clear means an operation was cut short
                            nxt_retry = retry_ff || !op_done_flag_n_i;
                            nxt_cnt = cyc_m1(`FBM_RP_CYC);
                            nxt_st = fbm_pkg::FBM_ST_CLR_LO;
                        end
                        default: begin
                            // Read; only the address-bit line is driven
                            nxt_ce_n = 1'b0;
                            nxt_oe_n = 1'b0;
                            nxt_dq_oe = byte_mode_i ? 16'h8000 : 16'h0000;
                            nxt_cnt = cyc_m1(`FBM_ACC_CYC);
                            nxt_st = fbm_pkg::FBM_ST_READ;
                        end
                    endcase
                end
            end
            fbm_pkg::FBM_ST_READ: begin
                if (cnt_ff == 16'h0000) begin
                    nxt_rdata = byte_n_ff ? data_lines_i : {8'h00, data_lines_i[7:0]};
                    nxt_rsp = 1'b1;
                    nxt_ce_n = 1'b1;
                    nxt_oe_n = 1'b1;
                    nxt_dq_oe = 16'h0000;
                    nxt_st = fbm_pkg::FBM_ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            fbm_pkg::FBM_ST_WR_LO: begin
                if (cnt_ff == 16'h0000) begin
                    nxt_we_n = 1'b1;                // Device latches data here
                    nxt_cnt = cyc_m1(`FBM_WPH_CYC);
                    nxt_st = fbm_pkg::FBM_ST_WR_HI;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            fbm_pkg::FBM_ST_WR_HI: begin
                if (cnt_ff == 16'h0000) begin
                    nxt_ce_n = 1'b1;
                    nxt_dq_oe = 16'h0000;
                    nxt_rsp = 1'b1;
                    nxt_st = fbm_pkg::FBM_ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            fbm_pkg::FBM_ST_CLR_LO: begin
                if (cnt_ff == 16'h0000) begin
                    nxt_clr_n = 1'b1;
                    nxt_cnt = cyc_m1(READY_CYC);
                    nxt_st = fbm_pkg::FBM_ST_CLR_WAIT;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            fbm_pkg::FBM_ST_CLR_WAIT: begin
                // Poll busy, bounded so a stuck flag cannot hang the host
                if (op_done_flag_n_i || cnt_ff == 16'h0000) begin
                    nxt_cnt = cyc_m1(`FBM_RH_CYC);
                    nxt_st = fbm_pkg::FBM_ST_CLR_RECOV;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            fbm_pkg::FBM_ST_CLR_RECOV: begin
                if (cnt_ff == 16'h0000) begin
                    nxt_rsp = 1'b1;
                    nxt_st = fbm_pkg::FBM_ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            default: begin
                nxt_st = fbm_pkg::FBM_ST_IDLE;
            end
        endcase
        nxt_ready = (nxt_st == fbm_pkg::FBM_ST_IDLE);
        // Level only raised outside clear; user asks for it only to program
        nxt_hv = accel_req_i && nxt_clr_n;
        nxt_prot = protect_i;
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= fbm_pkg::FBM_ST_IDLE;
            cnt_ff <= 16'h0000;
            ready_ff <= 1'b0;
            rsp_ff <= 1'b0;
            retry_ff <= 1'b0;
            rdata_ff <= 16'h0000;
            dq_ff <= 16'h0000;
            dq_oe_ff <= 16'h0000;
            ce_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            clr_n_ff <= 1'b1;
            byte_n_ff <= 1'b1;
            hv_ff <= 1'b0;
            prot_ff <= 1'b0;
            addr_ff <= 21'h000000;
        end else if (ce_i) begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            ready_ff <= nxt_ready;
            rsp_ff <= nxt_rsp;
            retry_ff <= nxt_retry;
            rdata_ff <= nxt_rdata;
            dq_ff <= nxt_dq;
            dq_oe_ff <= nxt_dq_oe;
            ce_n_ff <= nxt_ce_n;
            oe_n_ff <= nxt_oe_n;
            we_n_ff <= nxt_we_n;
            clr_n_ff <= nxt_clr_n;
            byte_n_ff <= nxt_byte_n;
            hv_ff <= nxt_hv;
            prot_ff <= nxt_prot;
            addr_ff <= nxt_addr;
        end
    end

    assign req_ready_o = ready_ff;
    assign rsp_valid_o = rsp_ff;
    assign rsp_rdata_o = rdata_ff;
    assign retry_o = retry_ff;
    assign flash_ce_n_o = ce_n_ff;
    assign flash_oe_n_o = oe_n_ff;
    assign flash_we_n_o = we_n_ff;
    assign flash_clear_n_o = clr_n_ff;
    assign flash_byte_n_o = byte_n_ff;
    assign flash_accel_hv_o = hv_ff;
    assign protect_accel_pin_o = prot_ff;
    assign flash_addr_o = addr_ff;
    assign data_lines_o = dq_ff;
    assign data_lines_oe_o = dq_oe_ff;

    // Helper counters for checking pulse widths
    logic [15:0] lo_len_ff, hi_len_ff, oe_len_ff;
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            lo_len_ff <= 16'h0000;
            hi_len_ff <= 16'hffff;
            oe_len_ff <= 16'h0000;
        end else if (ce_i) begin
            lo_len_ff <= clr_n_ff ? 16'h0000 : lo_len_ff + 16'h0001;
            oe_len_ff <= oe_n_ff ? 16'h0000 : oe_len_ff + 16'h0001;
            hi_len_ff <= !clr_n_ff ? 16'h0000 :
                         (hi_len_ff == 16'hffff ? hi_len_ff : hi_len_ff + 16'h0001);
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n);

    property p_write_levels;
        !flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o;
    endproperty
    a_write_levels: assert property (p_write_levels) else $error("bad write levels");

    property p_no_contention;
        (|data_lines_oe_o[14:0]) |-> flash_oe_n_o;
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("bus contention");

    property p_byte_lanes;
        !flash_byte_n_o && (|data_lines_oe_o) |-> data_lines_oe_o[14:8] == 7'h00;
    endproperty
    a_byte_lanes: assert property (p_byte_lanes) else $error("byte lanes driven");

    property p_hv_outside_clear;
        flash_accel_hv_o |-> flash_clear_n_o;
    endproperty
    a_hv_outside_clear: assert property (p_hv_outside_clear) else $error("hv in clear");

    property p_clear_width;
        $rose(flash_clear_n_o) |-> $past(lo_len_ff) == 16'(`FBM_RP_CYC - 1);
    endproperty
    a_clear_width: assert property (p_clear_width) else $error("clear pulse width");

    property p_quiet_in_clear;
        !flash_clear_n_o |-> flash_ce_n_o && flash_oe_n_o && flash_we_n_o;
    endproperty
    a_quiet_in_clear: assert property (p_quiet_in_clear) else $error("cycle in clear");

    property p_read_recovery;
        !flash_oe_n_o |-> hi_len_ff >= 16'(`FBM_RH_CYC);
    endproperty
    a_read_recovery: assert property (p_read_recovery) else $error("read too early");

    property p_retry_at_clear;
        $rose(retry_o) |-> !flash_clear_n_o && $past(ready_ff);
    endproperty
    a_retry_at_clear: assert property (p_retry_at_clear) else $error("retry without clear");

    property p_poll_busy;
        st_ff == fbm_pkg::FBM_ST_CLR_WAIT && ce_i && !op_done_flag_n_i && cnt_ff != 16'h0000
            |=> st_ff == fbm_pkg::FBM_ST_CLR_WAIT;
    endproperty
    a_poll_busy: assert property (p_poll_busy) else $error("left busy wait early");

    property p_read_access;
        // Gate must have stood low a full access time when data is taken
        $rose(flash_oe_n_o) |-> rsp_valid_o && oe_len_ff == 16'(`FBM_ACC_CYC);
    endproperty
    a_read_access: assert property (p_read_access) else $error("read too fast");

    c_read: cover property ($rose(flash_oe_n_o) && rsp_valid_o);
    c_write: cover property ($rose(flash_we_n_o) ##[1:40] rsp_valid_o);
    c_retry: cover property ($rose(retry_o));
    c_accel_write: cover property (flash_accel_hv_o && !flash_we_n_o);

endmodule : fbm_host

// >>> dv/fbm_flash_model.sv
// Purpose: Behavioural flash device facing the host controller
// Assumes: Pins sampled on the bench clock; 256-word array
// Notes: Program code is arbitrary; the two-cycle program and identification mode are modelled
`timescale 1ns/1ps
module fbm_flash_model #(
    parameter logic [15:0] PROG_CMD = 16'h00a0, // Arbitrary value
    parameter logic [15:0] ID_CMD = 16'h0090, // Arbitrary value
    parameter logic [15:0] ID_CODE = 16'h5c3e, // Arbitrary value
    parameter int BUSY_CYC = 60,
    parameter int RST_CYC = 135
) (
    input wire logic clk_i, // Bench clock
    input wire logic slow_i, // Long read access
    input wire logic ce_n_i, // Select
    input wire logic oe_n_i, // Gate
    input wire logic we_n_i, // Strobe
    input wire logic clear_n_i, // Hardware clear
    input wire logic byte_n_i, // Width
    input wire logic hv_i, // Accelerate level
    input wire logic prot_i, // Protect level
    input wire logic [20:0] addr_i, // Word address
    input wire logic [15:0] dq_i, // Resolved lines
    output logic [15:0] dq_o, // Drive data
    output logic [15:0] dq_oe_o, // Drive enable
    output logic busy_n_o, // Ready high
    output logic viol_o // Host broke a rule
);
    logic [15:0] mem [256];
    logic [15:0] pd, bcnt;
    logic [8:0] pa;
    logic [20:0] aq;
    logic [7:0] cnt, rh;
    logic we_q, clr_q, armed, pend, pb, idm;
    wire [15:0] w = mem[addr_i[7:0]];
    wire [15:0] w2 = mem[pa[8:1]];
    wire [15:0] wd = byte_n_i ? dq_i : {8'h00, dq_i[7:0]};
    wire [15:0] rd = byte_n_i ? w : {8'h00, dq_i[15] ? w[15:8] : w[7:0]};
    wire [15:0] rq = idm ? ID_CODE : rd;
    wire rd_en = !ce_n_i && !oe_n_i && clear_n_i;
    wire locked = addr_i[7:4] == 4'h0 && !prot_i && !hv_i;
    // Stale data until the access time runs out, never a kind copy
    // Count 16 at the host's sample edge means the address stood 72 ns
    assign dq_o = (cnt >= (slow_i ? 8'd16 : 8'd1)) ? rq : ~rq;
    assign dq_oe_o = !rd_en ? 16'h0000 : byte_n_i ? 16'hffff : 16'h00ff;
    assign busy_n_o = bcnt == 16'h0000;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = {i[7:0], ~i[7:0]};
        end
        {we_q, clr_q, armed, pend, pb, idm, viol_o, cnt, rh, bcnt, aq} = '0;
    end
    always @(posedge clk_i) begin
        we_q <= we_n_i;
        clr_q <= clear_n_i;
        aq <= addr_i;
        cnt <= (rd_en && addr_i == aq && cnt != 8'hff) ? cnt + 8'h01 : 8'h00;
        rh <= !clear_n_i ? 8'd13 : (rh != 8'h00) ? rh - 8'h01 : 8'h00;
        if (rd_en && rh != 8'h00)
            viol_o <= 1'b1;
        if (bcnt != 16'h0000)
            bcnt <= bcnt - 16'h0001;
        if (bcnt == 16'h0001 && pend) begin
            pend <= 1'b0;
            mem[pa[8:1]] <= !pb ? pd : pa[0] ? {pd[7:0], w2[7:0]} : {w2[15:8], pd[7:0]};
        end
        if (we_n_i && !we_q && !ce_n_i && clear_n_i) begin
            if (!oe_n_i)
                viol_o <= 1'b1;
            armed <= !armed && wd == PROG_CMD;
            // Any other write leaves identification mode
            idm <= wd == ID_CMD;
            if (armed && !locked && bcnt == 16'h0000) begin
                {pend, pb, pa, pd} <= {1'b1, !byte_n_i, addr_i[7:0], dq_i[15], wd};
                bcnt <= hv_i ? 16'(BUSY_CYC / 4) : 16'(BUSY_CYC);
            end
        end
        if (!clear_n_i) begin
            armed <= 1'b0;
            pend <= 1'b0;
            idm <= 1'b0;
            if (clr_q)
                bcnt <= (bcnt != 16'h0000) ? 16'(RST_CYC) : 16'h0000;
        end
    end
endmodule : fbm_flash_model

// >>> dv/fbm_host_tb.sv
// Purpose: Self-checking bench of the flash bus-mode host controller
// Assumes: Flash model runs on the bench clock; short busy bound
// Notes: Random reads come from an LFSR seeded at 77152
`timescale 1ns/1ps
`include "fbm_regs.svh"
module fbm_host_tb;
    localparam logic [15:0] CMD = 16'h00a0; // Arbitrary program code
    localparam logic [15:0] IDCMD = 16'h0090; // Arbitrary identification code
    localparam logic [15:0] IDC = 16'h5c3e; // Arbitrary identification value
    localparam int LIMIT = 20000;
    logic core_clk = 1'b0;
    logic nrst, ce, valid, byte_m, accel, prot, slow, ce_rand;
    logic [1:0] op;
    logic [21:0] addr;
    logic [15:0] wd, flt;
    logic [15:0] shadow [256];
    logic [31:0] lf = 32'd77152;
    wire ready, rsp, retry, ce_n, oe_n, we_n, clr_n, byte_n, hv, pin, busy_n, viol;
    wire [15:0] rdata, h_d, h_oe, f_d, f_oe, dq;
    wire [20:0] fa;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    int lat;
    fbm_host #(.READY_CYC(20)) i_fbm_host (
        .core_clk_i(core_clk), .nrst_i(nrst), .ce_i(ce), .req_valid_i(valid), .req_op_i(op),
        .req_addr_i(addr), .req_wdata_i(wd), .byte_mode_i(byte_m), .accel_req_i(accel),
        .protect_i(prot), .req_ready_o(ready), .rsp_valid_o(rsp), .rsp_rdata_o(rdata),
        .retry_o(retry), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n),
        .flash_clear_n_o(clr_n), .flash_byte_n_o(byte_n), .flash_accel_hv_o(hv),
        .protect_accel_pin_o(pin), .flash_addr_o(fa), .data_lines_o(h_d),
        .data_lines_oe_o(h_oe), .data_lines_i(dq), .op_done_flag_n_i(busy_n));
    fbm_flash_model #(.PROG_CMD(CMD), .ID_CMD(IDCMD), .ID_CODE(IDC)) i_fbm_flash_model (
        .clk_i(core_clk), .slow_i(slow), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .clear_n_i(clr_n), .byte_n_i(byte_n), .hv_i(hv), .prot_i(pin), .addr_i(fa),
        .dq_i(dq), .dq_o(f_d), .dq_oe_o(f_oe), .busy_n_o(busy_n), .viol_o(viol));
    // Undriven lines toggle so a stale value never looks valid
    assign dq = (h_oe & h_d) | (f_oe & f_d) | (~h_oe & ~f_oe & flt);
    initial forever #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        flt <= ~flt;
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fails = fails + 1;
            tally_and_finish();
        end
    end
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    function automatic logic [15:0] exp_rd(input logic [8:0] a, input logic bm);
        return bm ? {8'h00, a[0] ? shadow[a[8:1]][15:8] : shadow[a[8:1]][7:0]} : shadow[a[8:1]];
    endfunction : exp_rd
    task automatic put(input logic [8:0] a, input logic [15:0] d, input logic bm);
        if (!bm)
            shadow[a[8:1]] = d;
        else if (a[0])
            shadow[a[8:1]][15:8] = d[7:0];
        else
            shadow[a[8:1]][7:0] = d[7:0];
    endtask : put
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        n_tests++;
        if (seen !== expd) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expd);
        end
    endtask : check
    task automatic xfer(input logic [1:0] o, input logic [21:0] a, input logic [15:0] d,
                        input logic bm);
        logic en;
        @(negedge core_clk);
        {valid, op, addr, wd, byte_m, ce} = {1'b1, o, a, d, bm, 1'b1};
        while (ready !== 1'b1)
            @(negedge core_clk);
        @(negedge core_clk);
        valid = 1'b0;
        lat = 0;
        do begin
            en = ce;
            @(negedge core_clk);
            lat = lat + int'(en);
            lf = nxt(lf);
            ce = lf[0] | !ce_rand;
        end while (rsp !== 1'b1 && lat < 400);
    endtask : xfer
    task automatic rd(input logic [1:0] o, input logic [21:0] a, input logic bm);
        xfer(o, a, 16'h0000, bm);
        check({ready, lat[7:0]}, {1'b1, 8'(`FBM_ACC_CYC)});
        check(rdata, exp_rd(a[8:0], bm));
    endtask : rd
    task automatic prog(input logic [21:0] a, input logic [15:0] d, input logic bm);
        xfer(2'h1, a, CMD, bm);
        check(lat, `FBM_WP_CYC + `FBM_WPH_CYC);
        xfer(2'h1, a, d, bm);
        check({retry, lat[7:0]}, {1'b0, 8'(`FBM_WP_CYC + `FBM_WPH_CYC)});
    endtask : prog
    task automatic wait_idle();
        for (int i = 0; i < 200 && busy_n !== 1'b1; i++)
            @(negedge core_clk);
    endtask : wait_idle
    task automatic tally_and_finish();
        $display("comparisons=%0d mismatches=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    initial begin
        {nrst, ce, valid, byte_m, accel, prot, slow, ce_rand} = 8'h44;
        {op, addr, wd, flt} = {2'h0, 22'h000000, 16'h0000, 16'h5a5a};
        for (int i = 0; i < 256; i++) begin
            shadow[i] = {i[7:0], ~i[7:0]};
        end
        repeat (10) @(negedge core_clk);
        nrst = 1'b1;
        repeat (4) @(negedge core_clk);
        check({ce_n, oe_n, we_n, clr_n, ready, retry}, 6'h3e);
        for (int i = 0; i < 24; i++) begin
            lf = nxt(lf);
            slow = lf[3];
            ce_rand = i > 19;
            rd({2{lf[4]}}, lf[21:0], lf[9]);
        end
        ce_rand = 1'b0;
        xfer(2'h1, 22'h000aaa, IDCMD, 1'b0);
        xfer(2'h0, 22'h000002, 16'h0000, 1'b0);
        check(rdata, IDC);
        xfer(2'h1, 22'h000000, 16'h00f0, 1'b0);
        rd(2'h0, 22'h000002, 1'b0);
        $display("test random_reads done");
        prog(22'h000104, 16'hc3a5, 1'b0);
        put(9'h104, 16'hc3a5, 1'b0);
        rd(2'h0, 22'h000042, 1'b0);
        check(busy_n, 1'b0);
        wait_idle();
        rd(2'h0, 22'h000104, 1'b0);
        prog(22'h000107, 16'h0077, 1'b1);
        put(9'h107, 16'h0077, 1'b1);
        wait_idle();
        rd(2'h0, 22'h000107, 1'b1);
        $display("test program done");
        prot = 1'b0;
        prog(22'h000006, 16'h1234, 1'b0);
        wait_idle();
        rd(2'h0, 22'h000006, 1'b0);
        accel = 1'b1;
        prog(22'h000006, 16'h1234, 1'b0);
        put(9'h006, 16'h1234, 1'b0);
        check({pin, hv}, 2'h1);
        wait_idle();
        accel = 1'b0;
        rd(2'h0, 22'h000006, 1'b0);
        prot = 1'b1;
        $display("test accelerate done");
        prog(22'h000020, 16'hbeef, 1'b0);
        xfer(2'h2, 22'h000000, 16'h0000, 1'b0);
        check(retry, 1'b1);
        // Model busy ends 135 edges after the edge following the clear's fall
        check(lat, 137 + `FBM_RH_CYC);
        rd(2'h0, 22'h000020, 1'b0);
        prog(22'h000020, 16'hbeef, 1'b0);
        put(9'h020, 16'hbeef, 1'b0);
        wait_idle();
        rd(2'h0, 22'h000020, 1'b0);
        xfer(2'h2, 22'h000000, 16'h0000, 1'b0);
        check({retry, lat == `FBM_RP_CYC + 1 + `FBM_RH_CYC}, 2'h1);
        check(viol, 1'b0);
        $display("test clear done");
        tally_and_finish();
    end
endmodule : fbm_host_tb
